// >>> rtl/fault_irq_consts.svh
// Constants for the fault and light event interrupt block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef FAULT_IRQ_CONSTS_SVH
`define FAULT_IRQ_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define EVENT_STATUS_FLAGS_ADDR 8'h02
`define EVENT_IRQ_ENABLE_ADDR   8'h03
`define EVENT_STATUS_RESET      5'h00
`define EVENT_ENABLE_RESET      5'h00
`define RESERVED_READ           3'h0
`define UNMAPPED_READ           8'h00

// ****************************************************************
// Field positions, shared by both registers
// ****************************************************************
`define SHORT_FAULT_FLAG_BIT    4
`define OVERHEAT_FLAG_BIT       3
`define OVERVOLTAGE_FLAG_BIT    2
`define LIGHT_CMP_B_FLAG_BIT    1
`define LIGHT_CMP_A_FLAG_BIT    0
`define EVENT_COUNT             5
// Enabled edges after reset before the synchronised comparator level is trusted
`define SYNC_SETTLE_CYCLES      3'h5

// ****************************************************************
// Timing
// ****************************************************************
`define CLOCK_MHZ               250
`define IRQ_HOLDOFF_US          50
`define IRQ_HOLDOFF_CYCLES      (`IRQ_HOLDOFF_US * `CLOCK_MHZ)

`endif

// >>> rtl/fault_irq_pkg.sv
// Types for the fault and light event interrupt block.
// Assumes the constants header is compiled alongside.
`include "fault_irq_consts.svh"

package fault_irq_pkg;

  typedef logic [`EVENT_COUNT-1:0] event_vec_t;
  typedef logic [7:0]              reg_byte_t;

  // ****************************************************************
  // Interrupt line states, one-hot
  // ****************************************************************
  typedef enum logic [1:0] {
    IRQ_LIVE = 2'h1,
    IRQ_HOLD = 2'h2
  } irq_state_t;

endpackage

// >>> rtl/input_sync.sv
// Three-stage synchroniser with agreement filter.
// Assumes inputs are asynchronous levels; output only moves when
// the second and third stages agree.
`timescale 1ns/1ps

module input_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clock_enable,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // Stage 1 feeds stage 2 only; the filter looks at stages 2 and 3
  always_comb begin
    stable_next = (~(stage2_reg ^ stage3_reg) & stage2_reg) |
                  ((stage2_reg ^ stage3_reg) & stable_reg);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      stable_reg <= '0;
    end else if (clock_enable) begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable_out = stable_reg;

endmodule

// >>> rtl/fault_and_light_event_irq.sv
// Event status and interrupt gating for the LED driver faults and
// ambient light comparators.
// Assumes the register port is driven by the serial interface engine
// in the clock domain; detector and comparator levels are asynchronous.
`timescale 1ns/1ps
`include "fault_irq_consts.svh"

module fault_and_light_event_irq #(
  parameter int HOLDOFF_CYCLES = `IRQ_HOLDOFF_CYCLES,
  parameter int CNT_W          = $clog2(HOLDOFF_CYCLES + 1)
) (
  // Clock, reset, enable
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clock_enable,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire fault_irq_pkg::reg_byte_t reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output fault_irq_pkg::reg_byte_t   reg_rdata,
  // Detector levels, asynchronous
  input  wire logic                  short_detect,
  input  wire logic                  overheat_detect,
  input  wire logic                  overvoltage_detect,
  input  wire logic                  light_sensor_a_input,
  input  wire logic                  light_sensor_b_input,
  // Configuration from the mode logic, same clock
  input  wire logic                  light_cmp_a_enable,
  input  wire logic                  light_cmp_b_enable,
  input  wire logic                  irq_pulse_style,
  // Host interrupt
  output logic                       host_irq
);
  import fault_irq_pkg::*;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  event_vec_t raw_levels;
  event_vec_t sync_levels;

  assign raw_levels = {short_detect, overheat_detect, overvoltage_detect,
                       light_sensor_b_input, light_sensor_a_input};

  input_sync #(
    .WIDTH (`EVENT_COUNT)
  ) u_sync (
    .clock        (clock),
    .rst          (rst),
    .clock_enable (clock_enable),
    .async_in     (raw_levels),
    .stable_out   (sync_levels)
  );

  // ****************************************************************
  // Event detection and flags
  // ****************************************************************
  event_vec_t event_status_flags_reg;
  event_vec_t event_status_flags_next;
  event_vec_t event_irq_enable_reg;
  event_vec_t event_irq_enable_next;
  logic [1:0] cmp_prev_reg;
  logic [1:0] cmp_prev_next;
  logic [1:0] cmp_change;
  logic [2:0] cmp_settle_reg;
  logic [2:0] cmp_settle_next;
  logic       cmp_settled;
  event_vec_t set_vec;
  event_vec_t clr_vec;
  logic       status_wr;
  logic       enable_wr;
  logic       clear_attempt;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  always_comb begin
    status_wr     = reg_wr && addr_hit(reg_addr, `EVENT_STATUS_FLAGS_ADDR);
    enable_wr     = reg_wr && addr_hit(reg_addr, `EVENT_IRQ_ENABLE_ADDR);
    // Prev level tracks even while disabled so enabling never fires stale
    cmp_prev_next = {sync_levels[`LIGHT_CMP_B_FLAG_BIT], sync_levels[`LIGHT_CMP_A_FLAG_BIT]};
    // Synchroniser resets low; a pin idling high must not look like a change
    cmp_settled     = (cmp_settle_reg == `SYNC_SETTLE_CYCLES);
    cmp_settle_next = cmp_settled ? cmp_settle_reg : cmp_settle_reg + 3'h1;
    cmp_change    = (cmp_prev_next ^ cmp_prev_reg) & {2{cmp_settled}};
    set_vec       = '0;
    set_vec[`SHORT_FAULT_FLAG_BIT]  = sync_levels[`SHORT_FAULT_FLAG_BIT];
    set_vec[`OVERHEAT_FLAG_BIT]     = sync_levels[`OVERHEAT_FLAG_BIT];
    set_vec[`OVERVOLTAGE_FLAG_BIT]  = sync_levels[`OVERVOLTAGE_FLAG_BIT];
    set_vec[`LIGHT_CMP_B_FLAG_BIT]  = cmp_change[1] && light_cmp_b_enable;
    set_vec[`LIGHT_CMP_A_FLAG_BIT]  = cmp_change[0] && light_cmp_a_enable;
    // Only ones written to the status address clear; reads never do
    clr_vec       = status_wr ? reg_wdata[`EVENT_COUNT-1:0] : '0;
    clear_attempt = |clr_vec;
    // Set wins over clear; enable bits play no part in setting
    event_status_flags_next = (event_status_flags_reg & ~clr_vec) | set_vec;
    event_irq_enable_next   = enable_wr ? reg_wdata[`EVENT_COUNT-1:0] : event_irq_enable_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_status_flags_reg <= `EVENT_STATUS_RESET;
      event_irq_enable_reg   <= `EVENT_ENABLE_RESET;
      cmp_prev_reg           <= 2'h0;
      cmp_settle_reg         <= '0;
    end else if (clock_enable) begin
      event_status_flags_reg <= event_status_flags_next;
      event_irq_enable_reg   <= event_irq_enable_next;
      cmp_prev_reg           <= cmp_prev_next;
      cmp_settle_reg         <= cmp_settle_next;
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  reg_byte_t rdata_reg;
  reg_byte_t rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (addr_hit(reg_addr, `EVENT_STATUS_FLAGS_ADDR)) begin
        rdata_next = {`RESERVED_READ, event_status_flags_reg};
      end else if (addr_hit(reg_addr, `EVENT_IRQ_ENABLE_ADDR)) begin
        rdata_next = {`RESERVED_READ, event_irq_enable_reg};
      end else begin
        rdata_next = `UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= `UNMAPPED_READ;
    end else if (clock_enable) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Interrupt line
  // ****************************************************************
  irq_state_t       state_reg;
  irq_state_t       state_next;
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [CNT_W-1:0] hold_cnt_next;
  logic             irq_reg;
  logic             irq_next;
  logic             pending_next;

  always_comb begin
    state_next    = state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (state_reg)
      IRQ_LIVE: begin
        if (clear_attempt && irq_pulse_style) begin
          state_next    = IRQ_HOLD;
          hold_cnt_next = CNT_W'(HOLDOFF_CYCLES - 1);
        end
      end
      IRQ_HOLD: begin
        // A fresh clear attempt restarts the quiet window
        if (clear_attempt && irq_pulse_style) begin
          hold_cnt_next = CNT_W'(HOLDOFF_CYCLES - 1);
        end else if (hold_cnt_reg == '0) begin
          state_next = IRQ_LIVE;
        end else begin
          hold_cnt_next = hold_cnt_reg - CNT_W'(1);
        end
      end
      default: begin
        state_next    = IRQ_LIVE;
        hold_cnt_next = '0;
      end
    endcase
    pending_next = |(event_status_flags_next & event_irq_enable_next);
    // Level style never leaves live, so the line follows pending directly
    irq_next     = (state_next == IRQ_LIVE) && pending_next;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg    <= IRQ_LIVE;
      hold_cnt_reg <= '0;
      irq_reg      <= 1'b0;
    end else if (clock_enable) begin
      state_reg    <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      irq_reg      <= irq_next;
    end
  end

  assign host_irq = irq_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_short_sets: assert property (
    clock_enable && sync_levels[`SHORT_FAULT_FLAG_BIT] |=> event_status_flags_reg[`SHORT_FAULT_FLAG_BIT])
    else $error("short flag not set");
  chk_heat_sets: assert property (
    clock_enable && sync_levels[`OVERHEAT_FLAG_BIT] |=> event_status_flags_reg[`OVERHEAT_FLAG_BIT])
    else $error("overheat flag not set");
  chk_ov_sets: assert property (
    clock_enable && sync_levels[`OVERVOLTAGE_FLAG_BIT] |=> event_status_flags_reg[`OVERVOLTAGE_FLAG_BIT])
    else $error("overvoltage flag not set");
  chk_cmp_b_sets: assert property (
    clock_enable && light_cmp_b_enable && cmp_change[1] |=> event_status_flags_reg[`LIGHT_CMP_B_FLAG_BIT])
    else $error("comparator b flag not set");
  chk_cmp_a_sets: assert property (
    clock_enable && light_cmp_a_enable && cmp_change[0] |=> event_status_flags_reg[`LIGHT_CMP_A_FLAG_BIT])
    else $error("comparator a flag not set");
  chk_w1c_clears: assert property (
    clock_enable && clr_vec[`SHORT_FAULT_FLAG_BIT] && !set_vec[`SHORT_FAULT_FLAG_BIT]
    |=> !event_status_flags_reg[`SHORT_FAULT_FLAG_BIT])
    else $error("write one did not clear");
  chk_flags_hold: assert property (
    clock_enable |=> (($past(event_status_flags_reg) & ~$past(clr_vec) & ~event_status_flags_reg) == '0))
    else $error("flag lost without write one");
  chk_irq_enabled: assert property (
    clock_enable && ((event_status_flags_next & event_irq_enable_next) == '0) |=> !host_irq)
    else $error("interrupt without enabled flag");
  chk_cmp_off_quiet: assert property (
    clock_enable && !light_cmp_a_enable && !event_status_flags_reg[`LIGHT_CMP_A_FLAG_BIT]
    |=> !event_status_flags_reg[`LIGHT_CMP_A_FLAG_BIT])
    else $error("disabled comparator raised event");
  chk_holdoff_drop: assert property (
    clock_enable && irq_pulse_style && clear_attempt |=> !host_irq ##1 !host_irq)
    else $error("interrupt not dropped after clear");
  chk_holdoff_end: assert property (
    clock_enable && state_reg == IRQ_HOLD && hold_cnt_reg == '0 && !clear_attempt && pending_next
    |=> host_irq)
    else $error("interrupt not reasserted after hold-off");
  chk_level_steady: assert property (
    clock_enable && !irq_pulse_style && state_reg == IRQ_LIVE && host_irq
    && |(event_status_flags_reg & event_irq_enable_next & ~clr_vec) |=> host_irq)
    else $error("level interrupt dropped with pending event");
  chk_set_wins: assert property (
    clock_enable && |(set_vec & clr_vec)
    |=> ((event_status_flags_reg & $past(set_vec & clr_vec)) == $past(set_vec & clr_vec)))
    else $error("event lost against clear");

endmodule

// >>> sim/host_model.sv
// Host processor side of the event register port: byte reads and writes.
// Assumes the block takes a strobe at the rising edge while clock_enable is high.
`timescale 1ns/1ps

module host_model (
  // Clock
  input  wire logic                      clock,
  // Register port
  output logic [7:0]                     reg_addr,
  output fault_irq_pkg::reg_byte_t       reg_wdata,
  output logic                           reg_wr,
  output logic                           reg_rd,
  input  wire fault_irq_pkg::reg_byte_t  reg_rdata
);
  import fault_irq_pkg::*;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Released lines show the inverse, so stale values cannot look valid
  // A flag is cleared only by writing a one to its bit
  task automatic write_reg(input logic [7:0] addr, input reg_byte_t data);
    @(negedge clock);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge clock);
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output reg_byte_t data);
    @(negedge clock);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clock);
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    data = reg_rdata;
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the fault and light event interrupt block.
// Assumes the host model in its own file drives the register port.
`timescale 1ns/1ps
`include "fault_irq_consts.svh"

module tb;
  import fault_irq_pkg::*;

  localparam int HOLD = 8;

  logic        clock;
  logic        rst;
  logic        clock_enable;
  logic [7:0]  reg_addr;
  reg_byte_t   reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  reg_byte_t   reg_rdata;
  logic        short_detect;
  logic        overheat_detect;
  logic        overvoltage_detect;
  logic        light_sensor_a_input;
  logic        light_sensor_b_input;
  logic        light_cmp_a_enable;
  logic        light_cmp_b_enable;
  logic        irq_pulse_style;
  logic        host_irq;
  int          num_errors;
  int          n_tests;
  int          seed;
  int          st;
  int          en;
  int          cnt;
  logic [31:0] v;
  reg_byte_t   d;

  fault_and_light_event_irq #(.HOLDOFF_CYCLES(HOLD)) DUT (
    .clock(clock), .rst(rst), .clock_enable(clock_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .short_detect(short_detect), .overheat_detect(overheat_detect),
    .overvoltage_detect(overvoltage_detect), .light_sensor_a_input(light_sensor_a_input),
    .light_sensor_b_input(light_sensor_b_input), .light_cmp_a_enable(light_cmp_a_enable),
    .light_cmp_b_enable(light_cmp_b_enable), .irq_pulse_style(irq_pulse_style),
    .host_irq(host_irq));

  host_model host (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****************************************************************
  // Comparison and closing
  // ****************************************************************
  task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_irq(input logic exp);
    n_tests++;
    if (host_irq !== exp) begin
      num_errors++;
      $display("MISMATCH host_irq expected %b seen %b", exp, host_irq);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run needs about 750 cycles; the limit leaves wide margin
  initial begin
    #40000;
    num_errors++;
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'hcfa9123c;
    num_errors = 0;
    n_tests = 0;
    st = 0;
    en = 0;
    rst = 1'b1;
    clock_enable = 1'b1;
    {short_detect, overheat_detect, overvoltage_detect} = 3'h0;
    {light_sensor_a_input, light_sensor_b_input} = 2'h0;
    {light_cmp_a_enable, light_cmp_b_enable, irq_pulse_style} = 3'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    host.read_reg(`EVENT_STATUS_FLAGS_ADDR, d);
    check_reg("status reset", 8'h00, d);
    host.read_reg(`EVENT_IRQ_ENABLE_ADDR, d);
    check_reg("enable reset", 8'h00, d);
    host.read_reg(8'h07, d);
    check_reg("unmapped read", 8'h00, d);
    check_irq(1'b0);
    // A write while frozen must not land
    clock_enable = 1'b0;
    host.write_reg(`EVENT_IRQ_ENABLE_ADDR, 8'hff);
    clock_enable = 1'b1;
    host.read_reg(`EVENT_IRQ_ENABLE_ADDR, d);
    check_reg("enable frozen", 8'h00, d);
    $display("test reset and freeze done");

    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      host.write_reg(`EVENT_IRQ_ENABLE_ADDR, v[7:0]);
      en = v[4:0];
      light_cmp_a_enable = v[8];
      light_cmp_b_enable = v[9];
      @(negedge clock);
      {short_detect, overheat_detect, overvoltage_detect} = v[12:10];
      if (v[13]) light_sensor_a_input = ~light_sensor_a_input;
      if (v[14]) light_sensor_b_input = ~light_sensor_b_input;
      // Comparator changes while disabled are dropped
      st = st | {v[12:10], v[14] & v[9], v[13] & v[8]};
      repeat (8) @(negedge clock);
      {short_detect, overheat_detect, overvoltage_detect} = 3'h0;
      repeat (8) @(negedge clock);
      host.read_reg(`EVENT_STATUS_FLAGS_ADDR, d);
      check_reg("status", 8'(st), d);
      host.read_reg(`EVENT_IRQ_ENABLE_ADDR, d);
      check_reg("enable", 8'(en), d);
      check_irq(|(st & en));
      host.read_reg(`EVENT_STATUS_FLAGS_ADDR, d);
      check_reg("status reread", 8'(st), d);
      host.write_reg(`EVENT_STATUS_FLAGS_ADDR, v[23:16]);
      st = st & ~int'(v[23:16]);
      check_irq(|(st & en));
      host.read_reg(`EVENT_STATUS_FLAGS_ADDR, d);
      check_reg("status cleared", 8'(st), d);
    end
    $display("test random events done");

    host.write_reg(`EVENT_STATUS_FLAGS_ADDR, 8'h1f);
    host.write_reg(`EVENT_IRQ_ENABLE_ADDR, 8'h10);
    short_detect = 1'b1;
    repeat (8) @(negedge clock);
    check_irq(1'b1);
    host.write_reg(`EVENT_STATUS_FLAGS_ADDR, 8'h10);
    check_irq(1'b1);
    irq_pulse_style = 1'b1;
    host.write_reg(`EVENT_STATUS_FLAGS_ADDR, 8'h00);
    check_irq(1'b1);
    host.write_reg(`EVENT_STATUS_FLAGS_ADDR, 8'h10);
    cnt = 0;
    while (host_irq === 1'b0 && cnt < 100) begin
      cnt++;
      @(negedge clock);
    end
    check_reg("holdoff cycles", 8'(HOLD), 8'(cnt));
    host.read_reg(`EVENT_STATUS_FLAGS_ADDR, d);
    check_reg("status held", 8'h10, d);
    $display("test interrupt styles done");

    // Mid-run reset while a fault and an enabled comparator input stay high
    light_cmp_a_enable = 1'b1;
    light_sensor_a_input = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (12) @(negedge clock);
    check_irq(1'b0);
    host.read_reg(`EVENT_IRQ_ENABLE_ADDR, d);
    check_reg("enable after reset", 8'h00, d);
    host.read_reg(`EVENT_STATUS_FLAGS_ADDR, d);
    check_reg("status after reset", 8'h10, d);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
